// *** rmt_pkg.sv ***
// Purpose: shared constants and carrier types of the receiver modem tuning
//          register bank
// Assumes: 8-bit register port, modem clock at 125 MHz
// Notes:   every offset, field position and reset value is named here once, except RST_AFC_GEAR and RST_GAIN_LO, which are rmt_regs parameters
package rmt_pkg;

    // register offsets
    localparam logic [7:0] ADDR_BAT      = 8'h1b;
    localparam logic [7:0] ADDR_FILT     = 8'h1c;
    localparam logic [7:0] ADDR_AFC_GEAR = 8'h1d;
    localparam logic [7:0] ADDR_AFC_TIME = 8'h1e;
    localparam logic [7:0] ADDR_GSHIFT   = 8'h1f;
    localparam logic [7:0] ADDR_OSR_LO   = 8'h20;
    localparam logic [7:0] ADDR_OFF_HI   = 8'h21;
    localparam logic [7:0] ADDR_GAIN_HI  = 8'h24;
    localparam logic [7:0] ADDR_GAIN_LO  = 8'h25;

    // reset values
    localparam logic [7:0] RST_FILT     = 8'h01;
    localparam logic [5:0] RST_AFC_TIME = 6'h0a;
    localparam logic [7:0] RST_GSHIFT   = 8'h03;
    localparam logic [7:0] RST_OSR_LO   = 8'h64;
    localparam logic [7:0] RST_OFF_HI   = 8'h01;
    localparam logic [2:0] RST_GAIN_HI  = 3'h2;

    // field positions
    localparam int SKIP_BIT      = 7;
    localparam int DEC_LSB       = 4;
    localparam int FILSET_LSB    = 0;
    localparam int HALVE_BIT     = 7;
    localparam int AFC_EN_BIT    = 6;
    localparam int GEARH_LSB     = 4;
    localparam int GEARL_LSB     = 0;
    localparam int SHW_LSB       = 3;
    localparam int ANW_LSB       = 0;
    localparam int RXRDY_BIT     = 6;
    localparam int FAST_LSB      = 3;
    localparam int SLOW_LSB      = 0;
    localparam int OSRH_LSB      = 5;
    localparam int STALL_BIT     = 4;
    localparam int NCOH_LSB      = 0;

    // widths
    localparam int VBAT_W        = 5;
    localparam int OSR_W         = 11;
    localparam int GAIN_W        = 11;
    localparam int OSR_FRAC_W    = 3;

    // timing
    localparam int CLK_FREQ_KHZ  = 125_000;
    localparam int VBAT_SLEEP_MS = 1000;
    localparam int VBAT_SLEEP_CYC = VBAT_SLEEP_MS * CLK_FREQ_KHZ;
    localparam int SHW_TB_PER_UNIT = 2;

    typedef struct packed {
        logic              third_decimator_skip;
        logic [2:0]        dec_exp;
        logic [3:0]        filset;
        logic              afc_halve_tol;
        logic              afc_en;
        logic [1:0]        gear_high;
        logic [3:0]        gear_low;
        logic [2:0]        short_wait;
        logic [2:0]        ant_wait;
        logic              rxready;
        logic [2:0]        cr_fast;
        logic [2:0]        cr_slow;
        logic [OSR_W-1:0]  osr;
        logic              stall;
        logic [3:0]        nco_high;
        logic [GAIN_W-1:0] crgain;
    } rmt_cfg_s;

endpackage

// *** rmt_bat_meas.sv ***
// Purpose: battery level capture, paced by the sleep state
// Assumes: converter delivers a code with a valid pulse
// Notes:   the period counter restarts whenever sleep is entered
`timescale 1ns/1ns
module rmt_bat_meas #(
    parameter int SLEEP_CYC = rmt_pkg::VBAT_SLEEP_CYC
) (
    input  wire logic                     i_mclk,
    input  wire logic                     i_rst_n,
    input  wire logic                     i_sleep,
    input  wire logic                     i_conv_valid,
    input  wire logic [rmt_pkg::VBAT_W-1:0] i_conv_code,
    output logic      [rmt_pkg::VBAT_W-1:0] o_vbat,
    output logic                          o_update
);
    logic [31:0] per_cnt_ff;
    logic        due_ff;
    logic        take;

    // RULE2 sleep pacing
    assign take = i_conv_valid && (!i_sleep || due_ff);

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            per_cnt_ff <= 32'h0000_0000;
            due_ff     <= 1'b0;
        end else if (!i_sleep || take) begin
            per_cnt_ff <= 32'h0000_0000;
            due_ff     <= 1'b0;
        end else if (per_cnt_ff == 32'(SLEEP_CYC - 1)) begin
            due_ff     <= 1'b1;
        end else begin
            per_cnt_ff <= per_cnt_ff + 32'h0000_0001;
        end
    end

    // RULE1 five-bit level
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_vbat   <= '0;
            o_update <= 1'b0;
        end else begin
            o_update <= take;
            if (take) begin
                o_vbat <= i_conv_code;
            end
        end
    end

    chk_sleep_update_pace: assert property ( // RULE2
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_sleep && $past(i_sleep) && o_update) |->
            $past(per_cnt_ff) == 32'(SLEEP_CYC - 1))
        else $error("sleep battery update before period elapsed");

    chk_awake_follow: assert property ( // RULE2
        @(posedge i_mclk) disable iff (!i_rst_n)
        (!i_sleep && i_conv_valid) |=> (o_update && o_vbat == $past(i_conv_code)))
        else $error("awake battery code not captured");

endmodule // rmt_bat_meas

// *** rmt_regs.sv ***
// Purpose: modem tuning register bank: battery level, filter decimation,
//          frequency correction loop and bit clock recovery settings
// Assumes: plain register port, read data one cycle after the read strobe
// Notes:   unmapped offsets read zero and ignore writes
//
// Strobed register access was decided locally.
`timescale 1ns/1ns
// Behaviour
// RULE1: battery level five bits, read only
// RULE2: sleep refreshes level each second, else continuous
// RULE3: filter bit 7 skips third decimator
// RULE4: decimation exponent 6:4, coefficient set 3:0
// RULE5: gear bit 7 halves tolerated error
// RULE6: gear bit 6 enables loop, gears 5:4/3:0
// RULE7: pre-preamble wait (field+1) times two bits
// RULE8: zero short wait disables pre-preamble correction
// RULE9: timing bits 2:0 antenna wait in bits
// RULE10: gain shifted fast before, slow after preamble
// RULE11: software sets fast 000, slow 101
// RULE12: software sets noise bit only in direct mode
// RULE13: oversampling eleven bits, three fractional
// RULE14: oversampling upper bits from offset-high 7:5
// RULE15: software computes oversampling value
// RULE16: software keeps oversampling at least eight
// RULE17: software rewrites rate, offset, gain on change
// RULE18: offset-high 3:0 oscillator bits, bit 4 stall
// RULE19: software computes oscillator offset
// RULE20: defaults give 40 kbps, no Manchester
// RULE21: loop gain eleven bits in two registers
// RULE22: preamble indication steers gearshift and correction
module rmt_regs #(
    parameter int         SLEEP_CYC   = rmt_pkg::VBAT_SLEEP_CYC,
    parameter logic [7:0] RST_AFC_GEAR = 8'h40,
    parameter logic [7:0] RST_GAIN_LO  = 8'h00
) (
    input  wire logic                       i_mclk,
    input  wire logic                       i_rst_n,
    input  wire logic [7:0]                 i_addr,
    input  wire logic [7:0]                 i_wdata,
    input  wire logic                       i_wr,
    input  wire logic                       i_rd,
    output logic      [7:0]                 o_rdata,
    input  wire logic                       i_sleep,
    input  wire logic                       i_conv_valid,
    input  wire logic [rmt_pkg::VBAT_W-1:0] i_conv_code,
    input  wire logic                       i_preamble_det,
    input  wire logic                       i_bit_tick,
    input  wire logic                       i_ant_switch,
    output rmt_pkg::rmt_cfg_s               o_cfg,
    output logic      [7:0]                 o_osr_int,
    output logic      [rmt_pkg::GAIN_W-1:0] o_bcr_gain,
    output logic                            o_afc_active,
    output logic                            o_afc_step,
    output logic                            o_ant_busy
);
    logic [7:0] filt_ff;
    logic [7:0] gear_ff;
    logic [5:0] time_ff;
    logic [7:0] gshift_ff;
    logic [7:0] osr_lo_ff;
    logic [7:0] off_hi_ff;
    logic [2:0] gain_hi_ff;
    logic [7:0] gain_lo_ff;
    logic [7:0] rdata_ff;
    logic [rmt_pkg::VBAT_W-1:0] vbat;
    logic [3:0] wait_cnt_ff;
    logic [3:0] wait_tgt;
    logic [2:0] ant_cnt_ff;
    logic [rmt_pkg::GAIN_W-1:0] gain_ff;
    logic [rmt_pkg::GAIN_W-1:0] nxt_gain;
    logic       afc_step_ff;
    logic       pre_active;
    logic [7:0] rd_val;
    rmt_pkg::rmt_cfg_s cfg;

    rmt_bat_meas #(
        .SLEEP_CYC (SLEEP_CYC)
    ) u_bat (
        .i_mclk       (i_mclk),
        .i_rst_n      (i_rst_n),
        .i_sleep      (i_sleep),
        .i_conv_valid (i_conv_valid),
        .i_conv_code  (i_conv_code),
        .o_vbat       (vbat),
        .o_update     ()
    );

    // RULE20 reset defaults
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            filt_ff    <= rmt_pkg::RST_FILT;
            gear_ff    <= RST_AFC_GEAR;
            time_ff    <= rmt_pkg::RST_AFC_TIME;
            gshift_ff  <= rmt_pkg::RST_GSHIFT;
            osr_lo_ff  <= rmt_pkg::RST_OSR_LO;
            off_hi_ff  <= rmt_pkg::RST_OFF_HI;
            gain_hi_ff <= rmt_pkg::RST_GAIN_HI;
            gain_lo_ff <= RST_GAIN_LO;
        end else if (i_wr) begin
            unique case (i_addr)
                rmt_pkg::ADDR_FILT:     filt_ff    <= i_wdata;
                rmt_pkg::ADDR_AFC_GEAR: gear_ff    <= i_wdata;
                rmt_pkg::ADDR_AFC_TIME: time_ff    <= i_wdata[5:0];
                rmt_pkg::ADDR_GSHIFT:   gshift_ff  <= i_wdata;
                rmt_pkg::ADDR_OSR_LO:   osr_lo_ff  <= i_wdata;
                rmt_pkg::ADDR_OFF_HI:   off_hi_ff  <= i_wdata;
                rmt_pkg::ADDR_GAIN_HI:  gain_hi_ff <= i_wdata[2:0];
                rmt_pkg::ADDR_GAIN_LO:  gain_lo_ff <= i_wdata;
                // battery level is read only; other offsets are ignored
                default: ;
            endcase
        end
    end

    // field decode
    always_comb begin
        // RULE3 decimator skip
        cfg.third_decimator_skip = filt_ff[rmt_pkg::SKIP_BIT];
        // RULE4 decimation and coefficients
        cfg.dec_exp    = filt_ff[rmt_pkg::DEC_LSB +: 3];
        cfg.filset     = filt_ff[rmt_pkg::FILSET_LSB +: 4];
        // RULE5 halve tolerance
        cfg.afc_halve_tol = gear_ff[rmt_pkg::HALVE_BIT];
        // RULE6 loop enable and gears
        cfg.afc_en     = gear_ff[rmt_pkg::AFC_EN_BIT];
        cfg.gear_high  = gear_ff[rmt_pkg::GEARH_LSB +: 2];
        cfg.gear_low   = gear_ff[rmt_pkg::GEARL_LSB +: 4];
        cfg.short_wait = time_ff[rmt_pkg::SHW_LSB +: 3];
        // RULE9 antenna wait field
        cfg.ant_wait   = time_ff[rmt_pkg::ANW_LSB +: 3];
        cfg.rxready    = gshift_ff[rmt_pkg::RXRDY_BIT];
        cfg.cr_fast    = gshift_ff[rmt_pkg::FAST_LSB +: 3];
        cfg.cr_slow    = gshift_ff[rmt_pkg::SLOW_LSB +: 3];
        // RULE14 oversampling assembly
        cfg.osr        = {off_hi_ff[rmt_pkg::OSRH_LSB +: 3], osr_lo_ff};
        // RULE18 oscillator high bits and stall
        cfg.stall      = off_hi_ff[rmt_pkg::STALL_BIT];
        cfg.nco_high   = off_hi_ff[rmt_pkg::NCOH_LSB +: 4];
        // RULE21 eleven-bit loop gain
        cfg.crgain     = {gain_hi_ff, gain_lo_ff};
    end

    // config goes out from flip-flops directly
    assign o_cfg = cfg;

    // RULE13 integer cycles per bit
    assign o_osr_int = cfg.osr[rmt_pkg::OSR_W-1:rmt_pkg::OSR_FRAC_W];

    // RULE10 gearshift on preamble
    // RULE22 preamble steers gain
    assign nxt_gain = i_preamble_det ? (cfg.crgain >> cfg.cr_slow)
                                     : (cfg.crgain >> cfg.cr_fast);

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gain_ff <= '0;
        end else begin
            gain_ff <= nxt_gain;
        end
    end
    assign o_bcr_gain = gain_ff;

    // RULE8 zero wait disables
    // RULE22 preamble ends the wait phase
    assign pre_active = cfg.afc_en && !i_preamble_det &&
                        (cfg.short_wait != 3'h0);
    assign o_afc_active = cfg.afc_en &&
                          (i_preamble_det || cfg.short_wait != 3'h0);

    // RULE7 short wait length
    assign wait_tgt = 4'((cfg.short_wait + 4'h1) * rmt_pkg::SHW_TB_PER_UNIT);

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wait_cnt_ff <= 4'h0;
            afc_step_ff <= 1'b0;
        end else if (!pre_active) begin
            wait_cnt_ff <= 4'h0;
            afc_step_ff <= 1'b0;
        end else if (i_bit_tick && wait_cnt_ff == wait_tgt - 4'h1) begin
            wait_cnt_ff <= 4'h0;
            afc_step_ff <= 1'b1;
        end else begin
            wait_cnt_ff <= wait_cnt_ff + {3'h0, i_bit_tick};
            afc_step_ff <= 1'b0;
        end
    end
    assign o_afc_step = afc_step_ff;

    // RULE9 antenna wait countdown
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ant_cnt_ff <= 3'h0;
        end else if (i_ant_switch) begin
            ant_cnt_ff <= cfg.ant_wait;
        end else if (i_bit_tick && ant_cnt_ff != 3'h0) begin
            ant_cnt_ff <= ant_cnt_ff - 3'h1;
        end
    end
    assign o_ant_busy = (ant_cnt_ff != 3'h0);

    // read mux; reserved bits read zero
    always_comb begin
        unique case (i_addr)
            // RULE1 battery level read
            rmt_pkg::ADDR_BAT:      rd_val = {3'h0, vbat};
            rmt_pkg::ADDR_FILT:     rd_val = filt_ff;
            rmt_pkg::ADDR_AFC_GEAR: rd_val = gear_ff;
            rmt_pkg::ADDR_AFC_TIME: rd_val = {2'h0, time_ff};
            rmt_pkg::ADDR_GSHIFT:   rd_val = gshift_ff;
            rmt_pkg::ADDR_OSR_LO:   rd_val = osr_lo_ff;
            rmt_pkg::ADDR_OFF_HI:   rd_val = off_hi_ff;
            rmt_pkg::ADDR_GAIN_HI:  rd_val = {5'h00, gain_hi_ff};
            rmt_pkg::ADDR_GAIN_LO:  rd_val = gain_lo_ff;
            default:                rd_val = 8'h00;
        endcase
    end

    // data stands only in the cycle after the strobe
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= i_rd ? rd_val : 8'h00;
        end
    end
    assign o_rdata = rdata_ff;

    sequence s_osr_write;
        i_wr && i_addr == rmt_pkg::ADDR_OSR_LO;
    endsequence

    sequence s_osr_read;
        i_rd && i_addr == rmt_pkg::ADDR_OSR_LO;
    endsequence

    chk_osr_write_read: assert property ( // RULE14
        @(posedge i_mclk) disable iff (!i_rst_n)
        s_osr_write ##1 s_osr_read |=>
            o_rdata == $past(i_wdata, 2) &&
            o_cfg.osr[7:0] == $past(i_wdata, 2))
        else $error("oversampling low byte not written back");

    chk_bat_read_only: assert property ( // RULE1
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_rd && i_addr == rmt_pkg::ADDR_BAT) |=>
            o_rdata[7:5] == 3'h0 && o_rdata[4:0] == $past(vbat))
        else $error("battery level read wrong");

    chk_gain_fast_shift: assert property ( // RULE10
        @(posedge i_mclk) disable iff (!i_rst_n)
        !i_preamble_det |=>
            o_bcr_gain == ($past(cfg.crgain) >> $past(cfg.cr_fast)))
        else $error("pre-preamble gain not fast-shifted");

    chk_gain_slow_shift: assert property ( // RULE10
        @(posedge i_mclk) disable iff (!i_rst_n)
        i_preamble_det |=>
            o_bcr_gain == ($past(cfg.crgain) >> $past(cfg.cr_slow)))
        else $error("post-preamble gain not slow-shifted");

    chk_zero_wait_off: assert property ( // RULE8
        @(posedge i_mclk) disable iff (!i_rst_n)
        (cfg.short_wait == 3'h0 || i_preamble_det) |=> !o_afc_step)
        else $error("correction step with zero wait or after preamble");

    chk_step_after_wait: assert property ( // RULE7
        @(posedge i_mclk) disable iff (!i_rst_n)
        o_afc_step |-> $past(wait_cnt_ff) == $past(wait_tgt) - 4'h1 &&
            $past(i_bit_tick))
        else $error("correction step before full short wait");

    chk_ant_wait_load: assert property ( // RULE9
        @(posedge i_mclk) disable iff (!i_rst_n)
        i_ant_switch |=> ant_cnt_ff == $past(cfg.ant_wait))
        else $error("antenna wait not loaded");

    chk_skip_decode: assert property ( // RULE3
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_wr && i_addr == rmt_pkg::ADDR_FILT) |=>
            o_cfg.third_decimator_skip == $past(i_wdata[7]) &&
            o_cfg.dec_exp == $past(i_wdata[6:4]))
        else $error("filter bandwidth fields not decoded");

    chk_gear_decode: assert property ( // RULE6
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_wr && i_addr == rmt_pkg::ADDR_AFC_GEAR) |=>
            o_cfg.afc_en == $past(i_wdata[6]) &&
            o_cfg.afc_halve_tol == $past(i_wdata[7]))
        else $error("correction gear fields not decoded");

    sequence s_offhi_write;
        i_wr && i_addr == rmt_pkg::ADDR_OFF_HI;
    endsequence

    chk_offhi_decode: assert property ( // RULE18
        @(posedge i_mclk) disable iff (!i_rst_n)
        s_offhi_write |=>
            o_cfg.osr[10:8] == $past(i_wdata[7:5]) &&
            o_cfg.stall == $past(i_wdata[4]) &&
            o_cfg.nco_high == $past(i_wdata[3:0]))
        else $error("offset-high fields not decoded");

    chk_timing_decode: assert property ( // RULE9
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_wr && i_addr == rmt_pkg::ADDR_AFC_TIME) |=>
            o_cfg.short_wait == $past(i_wdata[5:3]) &&
            o_cfg.ant_wait == $past(i_wdata[2:0]))
        else $error("timing fields not decoded");

    chk_gain_low_write: assert property ( // RULE21
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_wr && i_addr == rmt_pkg::ADDR_GAIN_LO) |=>
            o_cfg.crgain[7:0] == $past(i_wdata))
        else $error("loop gain low byte not stored");

    chk_idle_no_afc: assert property ( // RULE8
        @(posedge i_mclk) disable iff (!i_rst_n)
        (cfg.short_wait == 3'h0 && !i_preamble_det) |-> !o_afc_active)
        else $error("correction active with zero short wait");

    chk_ant_countdown: assert property ( // RULE9
        @(posedge i_mclk) disable iff (!i_rst_n)
        (!i_ant_switch && i_bit_tick && o_ant_busy) |=>
            ant_cnt_ff == $past(ant_cnt_ff) - 3'h1)
        else $error("antenna wait did not count down");

endmodule // rmt_regs

// *** test_rmt_regs.sv ***
// Purpose: self-checking bench for the modem tuning register bank
// Assumes: SLEEP_CYC shortened to 20 cycles so the sleep pacing shows
// Notes:   expectations come from the field layout, never from the outputs
`timescale 1ns/1ns
module test_rmt_regs;
    localparam int SLP = 20;
    logic                       i_mclk;
    logic                       i_rst_n;
    logic [7:0]                 i_addr;
    logic [7:0]                 i_wdata;
    logic                       i_wr;
    logic                       i_rd;
    logic [7:0]                 o_rdata;
    logic                       i_sleep;
    logic                       i_conv_valid;
    logic [rmt_pkg::VBAT_W-1:0] i_conv_code;
    logic                       i_preamble_det;
    logic                       i_bit_tick;
    logic                       i_ant_switch;
    rmt_pkg::rmt_cfg_s          cfg;
    logic [7:0]                 o_osr_int;
    logic [rmt_pkg::GAIN_W-1:0] o_bcr_gain;
    logic                       o_afc_active;
    logic                       o_afc_step;
    logic                       o_ant_busy;
    int                         fails;
    int                         cmp_count;
    int                         step_cnt;
    logic [7:0]                 addrs [10];
    logic [7:0]                 masks [10];
    logic [7:0]                 pats  [2];

    rmt_regs #(.SLEEP_CYC(SLP)) i_dut (
        .i_mclk        (i_mclk),
        .i_rst_n       (i_rst_n),
        .i_addr        (i_addr),
        .i_wdata       (i_wdata),
        .i_wr          (i_wr),
        .i_rd          (i_rd),
        .o_rdata       (o_rdata),
        .i_sleep       (i_sleep),
        .i_conv_valid  (i_conv_valid),
        .i_conv_code   (i_conv_code),
        .i_preamble_det(i_preamble_det),
        .i_bit_tick    (i_bit_tick),
        .i_ant_switch  (i_ant_switch),
        .o_cfg         (cfg),
        .o_osr_int     (o_osr_int),
        .o_bcr_gain    (o_bcr_gain),
        .o_afc_active  (o_afc_active),
        .o_afc_step    (o_afc_step),
        .o_ant_busy    (o_ant_busy)
    );

    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end

    // pulses are counted so the check does not hinge on the exact cycle
    always @(posedge i_mclk) begin
        if (o_afc_step === 1'b1) begin
            step_cnt <= step_cnt + 1;
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd   <= 1'b0;
        #1;
        d = o_rdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        check({8'h00, v}, {8'h00, e});
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge i_mclk);
            i_bit_tick <= 1'b1;
            @(posedge i_mclk);
            i_bit_tick <= 1'b0;
        end
        #1;
    endtask

    task automatic conv(input logic [4:0] c);
        @(posedge i_mclk);
        i_conv_valid <= 1'b1;
        i_conv_code  <= c;
        @(posedge i_mclk);
        i_conv_valid <= 1'b0;
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // no test path is longer than a few thousand cycles
    initial begin
        #200000;
        fails++;
        final_report;
    end

    initial begin
        i_rst_n = 1'b0; i_addr = 8'h00; i_wdata = 8'h00; i_wr = 1'b0;
        i_rd = 1'b0; i_sleep = 1'b0; i_conv_valid = 1'b0;
        i_conv_code = 5'h00; i_preamble_det = 1'b0; i_bit_tick = 1'b0;
        i_ant_switch = 1'b0; fails = 0; cmp_count = 0; step_cnt = 0;
        addrs = '{8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h1f,
                  8'h20, 8'h21, 8'h24, 8'h25, 8'h30};
        masks = '{8'h00, 8'hff, 8'hff, 8'h3f, 8'hff,
                  8'hff, 8'hff, 8'h07, 8'hff, 8'h00};
        pats  = '{8'hff, 8'h5a};
        repeat (4) @(posedge i_mclk);
        // released between edges, away from the flops' sampling instant
        @(negedge i_mclk);
        i_rst_n <= 1'b1;
        // reset values; defaults give 12.5 samples per bit
        check({5'h00, cfg.osr}, 16'h0064);
        check({8'h00, o_osr_int}, 16'h000c);
        rd_chk(8'h1b, 8'h00);
        rd_chk(8'h1c, 8'h01);
        rd_chk(8'h1d, 8'h40);
        rd_chk(8'h1e, 8'h0a);
        rd_chk(8'h1f, 8'h03);
        rd_chk(8'h20, 8'h64);
        rd_chk(8'h21, 8'h01);
        rd_chk(8'h25, 8'h00);
        rd_chk(8'h24, 8'h02);
        @(posedge i_mclk);
        #1;
        check({8'h00, o_rdata}, 16'h0000);
        // access kinds: reserved bits, read-only and unmapped places
        foreach (pats[p]) begin
            foreach (addrs[i]) wr(addrs[i], pats[p]);
            foreach (addrs[i]) rd_chk(addrs[i], pats[p] & masks[i]);
        end
        // field decode of the filter, gear and offset-high registers
        wr(8'h1c, 8'hd5);
        wr(8'h1d, 8'ha7);
        wr(8'h21, 8'hb9);
        // write then read with no gap between the strobes
        @(posedge i_mclk);
        i_wr    <= 1'b1;
        i_addr  <= 8'h20;
        i_wdata <= 8'h64;
        @(posedge i_mclk);
        i_wr    <= 1'b0;
        i_rd    <= 1'b1;
        @(posedge i_mclk);
        i_rd    <= 1'b0;
        #1;
        check({8'h00, o_rdata}, 16'h0064);
        check({15'h0, cfg.rxready}, 16'h0001);
        check({15'h0, cfg.third_decimator_skip}, 16'h0001);
        check({13'h0, cfg.dec_exp}, 16'h0005);
        check({12'h0, cfg.filset}, 16'h0005);
        check({15'h0, cfg.afc_halve_tol}, 16'h0001);
        check({15'h0, cfg.afc_en}, 16'h0000);
        check({14'h0, cfg.gear_high}, 16'h0002);
        check({12'h0, cfg.gear_low}, 16'h0007);
        check({5'h00, cfg.osr}, 16'h0564);
        check({8'h00, o_osr_int}, 16'h00ac);
        check({15'h0, cfg.stall}, 16'h0001);
        check({12'h0, cfg.nco_high}, 16'h0009);
        check({15'h0, o_afc_active}, 16'h0000);
        // battery level: continuous when awake, paced in sleep
        conv(5'h15);
        rd_chk(8'h1b, 8'h15);
        i_sleep <= 1'b1;
        conv(5'h0a);
        rd_chk(8'h1b, 8'h15);
        repeat (SLP + 5) @(posedge i_mclk);
        conv(5'h0a);
        rd_chk(8'h1b, 8'h0a);
        conv(5'h03);
        rd_chk(8'h1b, 8'h0a);
        i_sleep <= 1'b0;
        conv(5'h1e);
        rd_chk(8'h1b, 8'h1e);
        // gain 0x540 shifted by fast 2, then slow 5 once preamble seen
        wr(8'h24, 8'h05);
        wr(8'h25, 8'h40);
        wr(8'h1f, 8'h15);
        repeat (3) @(posedge i_mclk);
        #1;
        check({5'h00, cfg.crgain}, 16'h0540);
        check({5'h00, o_bcr_gain}, 16'h0150);
        i_preamble_det <= 1'b1;
        repeat (3) @(posedge i_mclk);
        #1;
        check({5'h00, o_bcr_gain}, 16'h002a);
        i_preamble_det <= 1'b0;
        // correction steps every 2*(1+1) bit ticks before preamble
        wr(8'h1d, 8'h40);
        wr(8'h1e, 8'h0b);
        #1;
        check({15'h0, o_afc_active}, 16'h0001);
        tick(3);
        check(step_cnt[15:0], 16'h0000);
        tick(1);
        repeat (2) @(posedge i_mclk);
        check(step_cnt[15:0], 16'h0001);
        tick(4);
        repeat (2) @(posedge i_mclk);
        check(step_cnt[15:0], 16'h0002);
        // preamble ends the pre-preamble stepping
        i_preamble_det <= 1'b1;
        tick(8);
        check(step_cnt[15:0], 16'h0002);
        i_preamble_det <= 1'b0;
        // zero short wait gives no step at all
        wr(8'h1e, 8'h03);
        tick(8);
        repeat (2) @(posedge i_mclk);
        check(step_cnt[15:0], 16'h0002);
        // antenna wait of three bit periods
        @(posedge i_mclk);
        i_ant_switch <= 1'b1;
        @(posedge i_mclk);
        i_ant_switch <= 1'b0;
        #1;
        check({15'h0, o_ant_busy}, 16'h0001);
        tick(2);
        check({15'h0, o_ant_busy}, 16'h0001);
        tick(1);
        check({15'h0, o_ant_busy}, 16'h0000);
        final_report;
    end
endmodule // test_rmt_regs
